// File: src/srb_pkg.sv
// Shared constants for the serial receive buffer read engine
package srb_pkg;
  // Command codes as carried in the command word
  localparam logic [15:0] CMD_READ_BYTES = 16'h1132;
  localparam logic [15:0] CMD_READ_STRING = 16'h1133;
  // Cancel transaction types that end a pending read
  localparam logic [15:0] CANCEL_ALL = 16'h0001;
  localparam logic [15:0] CANCEL_READ = 16'h0002;
  // Destination memory type treated as word memory
  localparam logic [15:0] MEM_TYPE_WORD = 16'h0008;
  // Highest legal terminating character
  localparam logic [15:0] TERM_MAX = 16'h00ff;
  // Status word values written at completion
  localparam logic [15:0] STAT_DONE = 16'h0001;
  localparam logic [15:0] STAT_TIMEOUT = 16'h0002;
  localparam logic [15:0] STAT_BAD_CMD = 16'h0003;
  // Word offsets of the returned data area
  localparam logic [15:0] OFS_COUNT = 16'h0000;
  localparam logic [15:0] OFS_LEFT = 16'h0001;
  localparam logic [15:0] OFS_DATA = 16'h0002;
  // Receive buffer depth in characters, a power of two
  localparam int RX_DEPTH = 64;
  // One second of timeout expressed in clock cycles
  localparam int CLK_PERIOD_NS = 50;
  localparam int SECOND_NS = 1000000000;
  localparam int CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
endpackage

// File: src/srb_fifo.sv
// Flip-flop receive buffer with two peek ports and a pop of up to two characters
`timescale 1ns/1ps
module srb_fifo
  import srb_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = RX_DEPTH,
  parameter int AW = $clog2(DEPTH)
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic push_i,
  input wire logic [W-1:0] data_i,
  // Drain side
  input wire logic [1:0] pop_i,
  input wire logic [AW-1:0] off_i,
  output logic [W-1:0] peek_a_o,
  output logic [W-1:0] peek_b_o,
  output logic [AW:0] level_o,
  output logic full_o
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] level_q;
  logic push_ok;

  // A push while full is simply not stored; the caller flags overflow
  assign full_o = (level_q == (AW+1)'(DEPTH));
  assign push_ok = push_i && !full_o;
  assign level_o = level_q;
  assign peek_a_o = mem_q[rd_q + off_i];
  assign peek_b_o = mem_q[rd_q + off_i + AW'(1)];

  // Pointers and level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      level_q <= '0;
    end
    else
    begin
      wr_q <= wr_q + AW'(push_ok);
      rd_q <= rd_q + AW'(pop_i);
      level_q <= level_q + (AW+1)'(push_ok) - (AW+1)'(pop_i);
    end
  end

  // Storage needs no reset: only slots below the level are ever read
  always_ff @(posedge clk_i)
  begin
    if (push_ok)
      mem_q[wr_q] <= data_i;
  end
endmodule

// File: src/srb_timer.sv
// Whole-second timeout timer; a zero second count never expires
`timescale 1ns/1ps
module srb_timer
  import srb_pkg::*;
#(
  parameter int CYC_PER_SEC = CYCLES_PER_SEC
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [15:0] secs_i,
  // One-cycle expiry pulse
  output logic expired_o
);
  logic [31:0] pre_q;
  logic [15:0] sec_q;
  logic run_q;
  logic tick;

  assign tick = run_q && (pre_q == 32'(CYC_PER_SEC - 1));

  // Prescaler to seconds, then seconds down to expiry
  always_ff @(posedge clk_i)
  begin
    if (rst_i || stop_i)
    begin
      pre_q <= '0;
      sec_q <= '0;
      run_q <= 1'b0;
      expired_o <= 1'b0;
    end
    else if (start_i)
    begin
      pre_q <= '0;
      sec_q <= secs_i;
      run_q <= (secs_i != 16'h0000);
      expired_o <= 1'b0;
    end
    else
    begin
      pre_q <= tick ? 32'h0000_0000 : pre_q + 32'(run_q);
      sec_q <= tick ? sec_q - 16'h0001 : sec_q;
      run_q <= run_q && !(tick && sec_q == 16'h0001);
      expired_o <= tick && sec_q == 16'h0001;
    end
  end
endmodule

// File: src/srb_engine.sv
// Serial receive buffer and read-bytes / read-string command engine
`timescale 1ns/1ps
module srb_engine
  import srb_pkg::*;
#(
  parameter int DEPTH = RX_DEPTH,
  parameter int CYC_PER_SEC = CYCLES_PER_SEC
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Received characters from the serial framer
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // Command block fields
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_code_i,
  input wire logic [15:0] cmd_timeout_i,
  input wire logic [15:0] cmd_arg_i,
  input wire logic [15:0] cmd_mem_type_i,
  input wire logic [15:0] cmd_addr_i,
  output logic cmd_ready_o,
  // Cancel command
  input wire logic cancel_valid_i,
  input wire logic [15:0] cancel_type_i,
  // Destination word writes
  output logic wr_valid_o,
  output logic [15:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  output logic [1:0] wr_be_o,
  // Command status word
  output logic stat_valid_o,
  output logic [15:0] stat_word_o,
  // Port status
  input wire logic ovf_clear_i,
  output logic port_ovf_o,
  output logic port_by_data_o,
  output logic port_by_timeout_o,
  output logic [15:0] rx_level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;
  localparam logic [15:0] DEPTH_W = 16'(DEPTH);

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_WAIT = 6'h02,
    S_MOVE = 6'h04,
    S_CNT = 6'h08,
    S_LEFT = 6'h10,
    S_STAT = 6'h20
  } srb_state_t;

  srb_state_t state_q, state_d;
  logic str_q, word_q;
  logic [15:0] cnt_q, addr_q, stat_q, stat_d;
  logic [7:0] term_q;
  logic [LW-1:0] n_q, n_d, idx_q, idx_d, scan_q, scan_d;
  logic ovf_q, by_data_q, by_tmo_q, no_lim_q;
  logic wr_valid_q, stat_valid_q;
  logic [15:0] wr_addr_q, wr_data_q, wr_data_d;
  logic [1:0] wr_be_q;

  // Buffer side
  logic [7:0] peek_a, peek_b;
  logic [LW-1:0] level;
  logic full;
  logic [1:0] pop;

  // Timer side
  logic tmr_exp;

  // Decode of the incoming command and of the waiting conditions
  logic accept, is_bytes, is_string, bad_cmd, cancel_hit;
  logic bytes_ready, scan_valid, scan_hit, move_two, move_last;
  logic [LW-1:0] rem;

  assign accept = cmd_valid_i && (state_q == S_IDLE);
  assign is_bytes = (cmd_code_i == CMD_READ_BYTES);
  assign is_string = (cmd_code_i == CMD_READ_STRING);
  // A count the buffer can never hold would wait forever, so it is refused
  assign bad_cmd = !(is_bytes || is_string) ||
                   (is_string && cmd_arg_i > TERM_MAX) ||
                   (is_bytes && cmd_arg_i > DEPTH_W);
  assign cancel_hit = cancel_valid_i &&
                      (cancel_type_i == CANCEL_ALL || cancel_type_i == CANCEL_READ);
  assign bytes_ready = !str_q && (16'(level) >= cnt_q);
  assign scan_valid = str_q && (scan_q < level);
  assign scan_hit = scan_valid && (peek_a == term_q);
  assign rem = n_q - idx_q;
  assign move_two = (rem >= LW'(2));
  assign move_last = (rem <= LW'(2));
  assign pop = (state_q == S_MOVE) ? (move_two ? 2'd2 : 2'd1) : 2'd0;

  // Input buffer; arrivals while full are dropped inside it
  srb_fifo #(
    .W(8),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(rx_valid_i),
    .data_i(rx_data_i),
    .pop_i(pop),
    .off_i((state_q == S_WAIT) ? scan_q[AW-1:0] : AW'(0)),
    .peek_a_o(peek_a),
    .peek_b_o(peek_b),
    .level_o(level),
    .full_o(full)
  );

  // Timeout counts only while a read waits; a zero field disables it
  srb_timer #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(accept),
    .stop_i(state_q != S_WAIT && !accept),
    .secs_i(cmd_timeout_i),
    .expired_o(tmr_exp)
  );

  // Next state; data wins over a timeout that lands in the same cycle
  always_comb
  begin
    state_d = state_q;
    n_d = n_q;
    idx_d = idx_q;
    scan_d = scan_q;
    stat_d = stat_q;
    case (state_q)
      S_IDLE:
      begin
        idx_d = '0;
        scan_d = '0;
        if (accept)
        begin
          if (bad_cmd)
          begin
            stat_d = STAT_BAD_CMD;
            state_d = S_STAT;
          end
          else if (is_bytes && cmd_arg_i == 16'h0000)
          begin
            n_d = '0;
            state_d = S_CNT;
          end
          else
            state_d = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (cancel_hit)
          state_d = S_IDLE;
        else if (bytes_ready)
        begin
          n_d = LW'(cnt_q);
          state_d = S_MOVE;
        end
        else if (scan_hit)
        begin
          n_d = scan_q + LW'(1);
          state_d = S_MOVE;
        end
        else if (tmr_exp)
        begin
          stat_d = STAT_TIMEOUT;
          state_d = S_STAT;
        end
        else if (scan_valid)
          scan_d = scan_q + LW'(1);
      end
      S_MOVE:
      begin
        idx_d = idx_q + (move_two ? LW'(2) : LW'(1));
        if (move_last)
          state_d = S_CNT;
      end
      S_CNT:
        state_d = S_LEFT;
      S_LEFT:
      begin
        stat_d = STAT_DONE;
        state_d = S_STAT;
      end
      S_STAT:
        state_d = S_IDLE;
      default:
        state_d = S_IDLE;
    endcase
  end

  // Word to write: packed pair, delivered count or remaining count
  always_comb
  begin
    wr_data_d = 16'h0000;
    case (state_q)
      S_MOVE:
        wr_data_d = {move_two ? peek_b : 8'h00, peek_a};
      S_CNT:
        wr_data_d = 16'(n_q);
      S_LEFT:
        wr_data_d = 16'(level);
      default:
        wr_data_d = 16'h0000;
    endcase
  end

  // Control state, counters and status code
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= S_IDLE;
      n_q <= '0;
      idx_q <= '0;
      scan_q <= '0;
      stat_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      n_q <= n_d;
      idx_q <= idx_d;
      scan_q <= scan_d;
      stat_q <= stat_d;
    end
  end

  // Fields are held for the whole read since the caller may change its ports
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      str_q <= 1'b0;
      word_q <= 1'b0;
      cnt_q <= 16'h0000;
      addr_q <= 16'h0000;
      term_q <= 8'h00;
      no_lim_q <= 1'b0;
    end
    else if (accept)
    begin
      str_q <= is_string;
      word_q <= (cmd_mem_type_i == MEM_TYPE_WORD);
      cnt_q <= cmd_arg_i;
      addr_q <= cmd_addr_i;
      term_q <= cmd_arg_i[7:0];
      // Remembered so the checker knows this wait must never time out
      no_lim_q <= (cmd_timeout_i == 16'h0000);
    end
  end

  // Registered write port; status is only written on the way out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_valid_q <= 1'b0;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 16'h0000;
      wr_be_q <= 2'b00;
      stat_valid_q <= 1'b0;
    end
    else
    begin
      wr_valid_q <= (state_q == S_MOVE) || (state_q == S_CNT) || (state_q == S_LEFT);
      wr_addr_q <= (state_q == S_MOVE) ? addr_q + OFS_DATA + 16'(idx_q >> 1) :
                   (state_q == S_CNT) ? addr_q + OFS_COUNT : addr_q + OFS_LEFT;
      wr_data_q <= wr_data_d;
      // Byte memory keeps its odd high byte untouched; word memory gets zero
      wr_be_q <= (state_q == S_MOVE && !move_two && !word_q) ? 2'b01 : 2'b11;
      stat_valid_q <= (state_q == S_STAT);
    end
  end

  // Port status: overflow is sticky, and an arrival while full beats a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ovf_q <= 1'b0;
      by_data_q <= 1'b0;
      by_tmo_q <= 1'b0;
    end
    else
    begin
      ovf_q <= (rx_valid_i && full) || (ovf_q && !ovf_clear_i);
      if (state_q == S_STAT && stat_q != STAT_BAD_CMD)
      begin
        by_data_q <= (stat_q == STAT_DONE);
        by_tmo_q <= (stat_q == STAT_TIMEOUT);
      end
    end
  end

  // One-hot idle bit, so ready comes straight from a flip-flop
  assign cmd_ready_o = state_q[0];
  assign wr_valid_o = wr_valid_q;
  assign wr_addr_o = wr_addr_q;
  assign wr_data_o = wr_data_q;
  assign wr_be_o = wr_be_q;
  assign stat_valid_o = stat_valid_q;
  assign stat_word_o = stat_q;
  assign port_ovf_o = ovf_q;
  assign port_by_data_o = by_data_q;
  assign port_by_timeout_o = by_tmo_q;
  assign rx_level_o = 16'(level);

  // Checks kept beside the logic
  stat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_WAIT |-> !stat_valid_o)
    else $error("status written while read pending");
  zero_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && !bad_cmd && is_bytes && cmd_arg_i == 16'h0000 |->
    ##2 (wr_valid_o && wr_data_o == 16'h0000) ##1 (wr_valid_o && !$past(state_q == S_MOVE, 2)))
    else $error("zero count read moved data");
  cancel_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_WAIT && cancel_hit |=> state_q == S_IDLE ##1 (!stat_valid_o && !wr_valid_o))
    else $error("cancelled read still completed");
  ovf_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_valid_i && full && !ovf_clear_i |=> port_ovf_o && level == $past(level) - LW'($past(pop)))
    else $error("overflow not flagged or char stored");
  bad_nodata_a: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && bad_cmd |-> ##1 !wr_valid_o ##1 (!wr_valid_o && stat_valid_o &&
    stat_word_o == STAT_BAD_CMD))
    else $error("failed command wrote data");
  tmo_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_WAIT && tmr_exp && !cancel_hit && !bytes_ready && !scan_hit |=>
    level >= $past(level) ##1 (stat_valid_o && stat_word_o == STAT_TIMEOUT && !wr_valid_o))
    else $error("timeout lost buffer data");
  odd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_MOVE && !move_two && word_q |=> wr_data_o[15:8] == 8'h00 && wr_be_o == 2'b11)
    else $error("odd word high byte not zero");
  left_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_LEFT |=> wr_valid_o && wr_addr_o == $past(addr_q) + OFS_LEFT &&
    wr_data_o == 16'($past(level)))
    else $error("remaining count wrong");
  no_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_WAIT && no_lim_q |-> !tmr_exp)
    else $error("zero timeout expired");
endmodule

// File: sim/srb_mem_model.sv
// Destination word memory and status capture standing for the requesting program
`timescale 1ns/1ps
module srb_mem_model (
  // Clock
  input wire logic clk_i,
  // Word writes from the engine
  input wire logic wr_valid_i,
  input wire logic [15:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [1:0] wr_be_i,
  // Status word
  input wire logic stat_valid_i,
  input wire logic [15:0] stat_word_i,
  // Counters and last status word for the bench
  output logic [15:0] wr_cnt_o,
  output logic [15:0] stat_cnt_o,
  output logic [15:0] stat_last_o
);
  logic [15:0] mem [0:255];
  // A fill pattern shows which bytes a write left alone
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 16'haaaa;
    wr_cnt_o = 16'h0000;
    stat_cnt_o = 16'h0000;
    stat_last_o = 16'h0000;
  end
  // Byte enables decide which halves land; only the low address byte is kept
  always @(posedge clk_i)
  begin
    if (wr_valid_i === 1'b1)
    begin
      if (wr_be_i[0] === 1'b1)
        mem[wr_addr_i[7:0]][7:0] <= wr_data_i[7:0];
      if (wr_be_i[1] === 1'b1)
        mem[wr_addr_i[7:0]][15:8] <= wr_data_i[15:8];
      wr_cnt_o <= wr_cnt_o + 16'h0001;
    end
    if (stat_valid_i === 1'b1)
    begin
      stat_last_o <= stat_word_i;
      stat_cnt_o <= stat_cnt_o + 16'h0001;
    end
  end
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the receive buffer read engine
`timescale 1ns/1ps
module tb_top;
  import srb_pkg::*;
  localparam int CPS = 20;
  logic clk_i, rst_i, rx_valid_i, cmd_valid_i, cancel_valid_i, ovf_clear_i;
  logic [7:0] rx_data_i;
  logic [15:0] cmd_code_i, cmd_timeout_i, cmd_arg_i, cmd_mem_type_i, cmd_addr_i, cancel_type_i;
  logic cmd_ready_o, wr_valid_o, stat_valid_o, port_ovf_o, port_by_data_o, port_by_timeout_o;
  logic [15:0] wr_addr_o, wr_data_o, stat_word_o, rx_level_o, stat_cnt, wr_cnt, stat_last;
  logic [1:0] wr_be_o;
  logic [15:0] s0, w0;
  int num_errors = 0;
  int total_checks = 0;

  srb_engine #(.DEPTH(RX_DEPTH), .CYC_PER_SEC(CPS)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .cmd_timeout_i(cmd_timeout_i), .cmd_arg_i(cmd_arg_i),
    .cmd_mem_type_i(cmd_mem_type_i), .cmd_addr_i(cmd_addr_i), .cmd_ready_o(cmd_ready_o),
    .cancel_valid_i(cancel_valid_i), .cancel_type_i(cancel_type_i), .wr_valid_o(wr_valid_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_be_o(wr_be_o),
    .stat_valid_o(stat_valid_o), .stat_word_o(stat_word_o), .ovf_clear_i(ovf_clear_i),
    .port_ovf_o(port_ovf_o), .port_by_data_o(port_by_data_o),
    .port_by_timeout_o(port_by_timeout_o), .rx_level_o(rx_level_o));

  srb_mem_model i_mem (.clk_i(clk_i), .wr_valid_i(wr_valid_o), .wr_addr_i(wr_addr_o),
    .wr_data_i(wr_data_o), .wr_be_i(wr_be_o), .stat_valid_i(stat_valid_o),
    .stat_word_i(stat_word_o), .wr_cnt_o(wr_cnt), .stat_cnt_o(stat_cnt),
    .stat_last_o(stat_last));

  // Free-running 20 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Streams n characters back to back, cycling through the four bytes of cs
  task automatic push_str(input logic [31:0] cs, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      rx_valid_i <= 1'b1;
      rx_data_i <= cs[8*(i%4) +: 8];
    end
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
  endtask

  // Offers one command block once the engine is idle; taken at the edge that drops valid
  task automatic issue(input logic [15:0] code, to, arg, mt, addr);
    int k;
    k = 0;
    #1;
    s0 = stat_cnt;
    w0 = wr_cnt;
    while (cmd_ready_o !== 1'b1 && k < 400)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (k == 400)
    begin
      check("ready wait", cmd_ready_o, 16'h0001);
      tally_and_finish();
    end
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_code_i <= code;
    cmd_timeout_i <= to;
    cmd_arg_i <= arg;
    cmd_mem_type_i <= mt;
    cmd_addr_i <= addr;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
  endtask

  // Waits under a bound for the status pulse, then lets the port bits settle
  task automatic wait_stat(input logic [15:0] exp, input string name);
    int k;
    k = 0;
    while (stat_cnt === s0 && k < 400)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (k == 400)
    begin
      check({name, " pulse"}, stat_cnt - s0, 16'h0001);
      tally_and_finish();
    end
    check(name, stat_last, exp);
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic cancel(input logic [15:0] t);
    @(posedge clk_i);
    cancel_valid_i <= 1'b1;
    cancel_type_i <= t;
    @(posedge clk_i);
    cancel_valid_i <= 1'b0;
  endtask

  // Main sequence: each read leaves a known buffer level for the next
  initial
  begin
    rst_i = 1'b1;
    {rx_valid_i, cmd_valid_i, cancel_valid_i, ovf_clear_i} = 4'h0;
    rx_data_i = 8'h00;
    {cmd_code_i, cmd_timeout_i, cmd_arg_i, cmd_mem_type_i, cmd_addr_i} = '0;
    cancel_type_i = 16'h0000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("ready", cmd_ready_o, 16'h0001);
    check("level", rx_level_o, 16'h0000);
    push_str(32'h00333231, 3);
    issue(CMD_READ_BYTES, 16'h0000, 16'h0003, MEM_TYPE_WORD, 16'h0010);
    wait_stat(STAT_DONE, "stat bytes");
    check("w2", i_mem.mem[8'h12], 16'h3231);
    check("w3", i_mem.mem[8'h13], 16'h0033);
    check("count", i_mem.mem[8'h10], 16'h0003);
    check("left", i_mem.mem[8'h11], 16'h0000);
    check("by data", port_by_data_o, 16'h0001);
    push_str(32'h00004241, 2);
    issue(CMD_READ_BYTES, 16'h0001, 16'h0000, MEM_TYPE_WORD, 16'h0020);
    wait_stat(STAT_DONE, "stat zero");
    check("zero count", i_mem.mem[8'h20], 16'h0000);
    check("zero left", i_mem.mem[8'h21], 16'h0002);
    check("zero writes", wr_cnt - w0, 16'h0002);
    issue(CMD_READ_BYTES, 16'h0001, 16'h0003, MEM_TYPE_WORD, 16'h0030);
    wait_stat(STAT_TIMEOUT, "stat timeout");
    check("fail writes", wr_cnt - w0, 16'h0000);
    check("fail level", rx_level_o, 16'h0002);
    check("by timeout", port_by_timeout_o, 16'h0001);
    issue(CMD_READ_BYTES, 16'h0000, 16'h0003, 16'h0000, 16'h0040);
    repeat (60) @(posedge clk_i);
    #1;
    check("no limit", stat_cnt, s0);
    check("pending", cmd_ready_o, 16'h0000);
    push_str(32'h00000078, 1);
    wait_stat(STAT_DONE, "stat late");
    check("late w2", i_mem.mem[8'h42], 16'h4241);
    check("byte mem w3", i_mem.mem[8'h43], 16'haa78);
    check("by data late", port_by_data_o, 16'h0001);
    push_str(32'h7a0d6261, 4);
    issue(CMD_READ_STRING, 16'h0001, 16'h000d, MEM_TYPE_WORD, 16'h0050);
    wait_stat(STAT_DONE, "stat string");
    check("str w2", i_mem.mem[8'h52], 16'h6261);
    check("str w3", i_mem.mem[8'h53], 16'h000d);
    check("str count", i_mem.mem[8'h50], 16'h0003);
    check("str left", i_mem.mem[8'h51], 16'h0001);
    issue(CMD_READ_STRING, 16'h0000, 16'h000a, MEM_TYPE_WORD, 16'h0060);
    cancel(16'h0003);
    repeat (40) @(posedge clk_i);
    #1;
    check("str pending", cmd_ready_o, 16'h0000);
    cancel(CANCEL_READ);
    repeat (3) @(posedge clk_i);
    #1;
    check("cancel read", cmd_ready_o, 16'h0001);
    check("cancel silent", stat_cnt, s0);
    issue(CMD_READ_STRING, 16'h0000, 16'h000a, MEM_TYPE_WORD, 16'h0060);
    cancel(CANCEL_ALL);
    repeat (3) @(posedge clk_i);
    #1;
    check("cancel all", cmd_ready_o, 16'h0001);
    check("cancel nothing", wr_cnt - w0, 16'h0000);
    issue(CMD_READ_STRING, 16'h0001, 16'h000a, MEM_TYPE_WORD, 16'h0070);
    wait_stat(STAT_TIMEOUT, "stat str timeout");
    check("str by timeout", port_by_timeout_o, 16'h0001);
    check("str kept", rx_level_o, 16'h0001);
    issue(CMD_READ_STRING, 16'h0001, TERM_MAX + 16'h0001, MEM_TYPE_WORD, 16'h0080);
    wait_stat(STAT_BAD_CMD, "stat bad term");
    check("bad writes", wr_cnt - w0, 16'h0000);
    check("bad keeps cause", port_by_timeout_o, 16'h0001);
    // Unknown code and a count the buffer can never hold are both refused
    issue(16'h1134, 16'h0001, 16'h0001, MEM_TYPE_WORD, 16'h0090);
    wait_stat(STAT_BAD_CMD, "stat bad code");
    issue(CMD_READ_BYTES, 16'h0001, 16'(RX_DEPTH + 1), MEM_TYPE_WORD, 16'h00a0);
    wait_stat(STAT_BAD_CMD, "stat bad count");
    check("bad count writes", wr_cnt - w0, 16'h0000);
    check("bad count level", rx_level_o, 16'h0001);
    push_str(32'h01020304, 70);
    #1;
    check("full level", rx_level_o, 16'(RX_DEPTH));
    check("overflow", port_ovf_o, 16'h0001);
    @(posedge clk_i);
    ovf_clear_i <= 1'b1;
    @(posedge clk_i);
    ovf_clear_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("ovf cleared", port_ovf_o, 16'h0000);
    tally_and_finish();
  end
endmodule
